// [dv/dmb_master_model.sv]
// bus master model that offers one register beat at a time to the bank
// assumes the bank answers exactly one cycle after it takes a beat
`timescale 1ns/100ps
`default_nettype none

module dmb_master_model (
    // clock
    input  wire logic               clk_i,
    // request beat to the bank
    output logic                    req_valid_o,
    output dmb_pkg::dmb_code_t      req_func_o,
    output dmb_pkg::dmb_word_t      req_addr_o,
    output dmb_pkg::dmb_word_t      req_wdata_o,
    // answer beat from the bank
    input  wire logic               rsp_valid_i,
    input  wire dmb_pkg::dmb_word_t rsp_data_i,
    input  wire dmb_pkg::dmb_code_t rsp_exc_i
);
    // ****************************************
    // idle lines
    // ****************************************
    initial
    begin
        req_valid_o = 1'b0;
        req_func_o  = 8'hFF;
        req_addr_o  = 16'hFFFF;
        req_wdata_o = 16'hFFFF;
    end

    // ****************************************
    // one beat and its answer
    // ****************************************
    // released lines are inverted so a stale value never looks like a beat
    task automatic xfer(input dmb_pkg::dmb_code_t func,
                        input dmb_pkg::dmb_word_t addr,
                        input dmb_pkg::dmb_word_t wdata,
                        output dmb_pkg::dmb_word_t data,
                        output dmb_pkg::dmb_code_t exc,
                        output logic seen);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_func_o  <= func;
        req_addr_o  <= addr;
        req_wdata_o <= wdata;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_func_o  <= ~func;
        req_addr_o  <= ~addr;
        req_wdata_o <= ~wdata;
        // answer stands for the cycle after the taking edge; sample it
        // mid-cycle where it is settled, not in the edge's own time step
        @(negedge clk_i);
        seen = rsp_valid_i;
        data = rsp_data_i;
        exc  = rsp_exc_i;
    endtask
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the damper register bank
// assumes the bank, its package and constants header compile beforehand
`timescale 1ns/100ps
`default_nettype none
`include "dmb_consts.svh"

module tb_top;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cmd_done_i = 1'b0;
    logic               req_valid, rsp_valid;
    dmb_pkg::dmb_code_t req_func, rsp_exc;
    dmb_pkg::dmb_word_t req_addr, req_wdata, rsp_data, demand_o, command_o;
    dmb_pkg::dmb_word_t meas [8];
    dmb_pkg::dmb_word_t nv [4] = '{16'h03E8, 16'h2328, 16'h0001, 16'h0032};
    dmb_pkg::dmb_word_t nv_o [4];
    dmb_pkg::dmb_word_t rd_tab [13] = '{16'h0003, 16'h0004, 16'h0005,
        16'h0006, 16'h0007, 16'h0008, 16'h0064, 16'h0065, 16'h0066,
        16'h0067, 16'h0068, 16'h006D, 16'h006E};
    dmb_pkg::dmb_word_t bad_tab [4] = '{16'h0009, 16'h0063, 16'h006F, 16'hFFFF};
    dmb_pkg::dmb_word_t dem_tab [4] = '{16'h1388, `DMB_PCT_FULL, 16'h0000,
        16'h07D0};
    int                 failures = 0;
    int                 num_checks = 0;

    // ****************************************
    // clock, retained store, instances
    // ****************************************
    always #5 clk_i = ~clk_i;

    // store keeps what the bank hands out, as the retained memory would
    always @(posedge clk_i)
        if (!rst_i)
            nv <= nv_o;

    dmb_regbank #(.SERIAL_1(16'h0A11), .SERIAL_2(16'h0B22),
        .SERIAL_4(16'h0C44), .VERSION(16'h0203)) dmb_regbank_i (
        .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_func_i(req_func), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .rsp_exc_o(rsp_exc),
        .category_i(meas[0]), .pos_pct_i(meas[1]), .pos_abs_i(meas[2]),
        .flow_pct_i(meas[3]), .flow_abs_i(meas[4]), .aux_val_i(meas[5]),
        .faults_i(meas[6]), .rated_i(meas[7]),
        .nv_lower_i(nv[0]), .nv_upper_i(nv[1]), .nv_aux_kind_i(nv[2]),
        .nv_loss_pos_i(nv[3]), .nv_lower_o(nv_o[0]), .nv_upper_o(nv_o[1]),
        .nv_aux_kind_o(nv_o[2]), .nv_loss_pos_o(nv_o[3]),
        .demand_o(demand_o), .command_o(command_o), .cmd_done_i(cmd_done_i));

    dmb_master_model dmb_master_model_i (
        .clk_i(clk_i), .req_valid_o(req_valid), .req_func_o(req_func),
        .req_addr_o(req_addr), .req_wdata_o(req_wdata),
        .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .rsp_exc_i(rsp_exc));

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic check(input dmb_pkg::dmb_word_t seen,
                         input dmb_pkg::dmb_word_t want, input string what);
        num_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one beat with expected answer data and exception code
    task automatic acc(input dmb_pkg::dmb_code_t f, input dmb_pkg::dmb_word_t a,
                       input dmb_pkg::dmb_word_t w, input dmb_pkg::dmb_word_t d,
                       input dmb_pkg::dmb_code_t e);
        dmb_pkg::dmb_word_t data;
        dmb_pkg::dmb_code_t exc;
        logic               seen;
        dmb_master_model_i.xfer(f, a, w, data, exc, seen);
        check({15'h0000, seen}, 16'h0001, "answer timing");
        check(data, d, "answer data");
        check({8'h00, exc}, {8'h00, e}, "answer code");
    endtask

    // expected read value of a mapped entry
    function automatic dmb_pkg::dmb_word_t exp_rd(input dmb_pkg::dmb_word_t a);
        case (a)
            16'h0064: return 16'h0A11;
            16'h0065: return 16'h0B22;
            16'h0066: return 16'h0C44;
            16'h0067: return 16'h0203;
            16'h0068: return meas[6];
            16'h006E: return meas[7];
            16'h006D: return 16'h0000;
            default:  return meas[a - 16'h0003];
        endcase
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        meas = '{16'h0002, 16'h1F40, 16'h005F, 16'h0FA0, 16'h0320, 16'h2AF8,
                 16'hA5C3, 16'h01F4};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        check(demand_o, 16'h0000, "demand after reset");
        check(command_o, 16'h0000, "command after reset");
        check(nv_o[0], 16'h03E8, "retained load");
        // every read-only entry through both read functions
        foreach (rd_tab[i])
        begin
            acc(`DMB_FC_RD_HOLD, rd_tab[i], 16'h0, exp_rd(rd_tab[i]), 8'h00);
            acc(`DMB_FC_RD_INPUT, rd_tab[i], 16'h0, exp_rd(rd_tab[i]), 8'h00);
        end
        foreach (bad_tab[i])
            acc(`DMB_FC_RD_HOLD, bad_tab[i], 16'h0, 16'h0, `DMB_EXC_ADDR);
        acc(8'h05, 16'h0000, 16'h0, 16'h0, `DMB_EXC_FUNC);
        // fault word bit by bit, then just outside the bit window
        for (int i = 0; i < 16; i++)
            acc(`DMB_FC_RD_BITS, `DMB_BIT_BASE + 16'(i), 16'h0,
                {15'h0000, meas[6][i]}, 8'h00);
        acc(`DMB_FC_RD_BITS, `DMB_BIT_BASE - 16'h1, 16'h0, 16'h0, 8'h02);
        acc(`DMB_FC_RD_BITS, `DMB_BIT_BASE + `DMB_BIT_COUNT, 16'h0, 16'h0,
            8'h02);
        // setpoint boundary, over range refused and left unchanged
        acc(`DMB_FC_WR_SINGLE, 16'h0, `DMB_PCT_FULL, `DMB_PCT_FULL, 8'h00);
        @(negedge clk_i);
        check(demand_o, `DMB_PCT_FULL, "full demand");
        acc(`DMB_FC_WR_SINGLE, 16'h0, 16'h2711, 16'h0, `DMB_EXC_VALUE);
        acc(`DMB_FC_RD_HOLD, 16'h0, 16'h0, `DMB_PCT_FULL, 8'h00);
        acc(`DMB_FC_WR_MULTI, 16'h0, 16'h1388, 16'h1388, 8'h00);
        acc(`DMB_FC_WR_MULTI, 16'h0069, 16'h07D0, 16'h07D0, 8'h00);
        @(negedge clk_i);
        check(nv_o[0], 16'h07D0, "retained write");
        // every override code and its effective demand
        for (int i = 0; i < 4; i++)
        begin
            acc(`DMB_FC_WR_SINGLE, 16'h1, 16'(i), 16'(i), 8'h00);
            @(negedge clk_i);
            check(demand_o, dem_tab[i], "override demand");
        end
        acc(`DMB_FC_WR_SINGLE, 16'h1, 16'h4, 16'h0, `DMB_EXC_VALUE);
        // every service command, cleared by the core's done pulse
        for (int i = 1; i < 5; i++)
        begin
            acc(`DMB_FC_WR_SINGLE, 16'h2, 16'(i), 16'(i), 8'h00);
            check(command_o, 16'(i), "command set");
            // done pulse driven on the rising edge, seen at the next one
            @(posedge clk_i);
            cmd_done_i <= 1'b1;
            @(posedge clk_i);
            cmd_done_i <= 1'b0;
            @(negedge clk_i);
            check(command_o, 16'h0, "command cleared");
        end
        acc(`DMB_FC_WR_SINGLE, 16'h2, 16'h5, 16'h0, `DMB_EXC_VALUE);
        acc(`DMB_FC_WR_SINGLE, 16'h3, 16'h1, 16'h0, `DMB_EXC_ADDR);
        acc(`DMB_FC_WR_MULTI, 16'h006D, 16'h1, 16'h0, `DMB_EXC_ADDR);
        // second reset: operation values lost, service values kept
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        acc(`DMB_FC_RD_HOLD, 16'h0, 16'h0, 16'h0, 8'h00);
        acc(`DMB_FC_RD_HOLD, 16'h1, 16'h0, 16'h0, 8'h00);
        acc(`DMB_FC_RD_HOLD, 16'h0069, 16'h0, 16'h07D0, 8'h00);
        // master refreshes the volatile setpoint after the loss
        acc(`DMB_FC_WR_SINGLE, 16'h0, 16'h0BB8, 16'h0BB8, 8'h00);
        @(negedge clk_i);
        check(demand_o, 16'h0BB8, "refreshed demand");
        report_and_stop();
    end
endmodule

`default_nettype wire

// [logic/dmb_consts.svh]
// constants of the damper actuator modbus register bank
// assumes a modbus framer outside that hands over one register per beat
// Overview of operation
// - one flat table, address is number minus one
// - every entry reachable by holding-register functions
// - functions 3 and 6 always supported
// - functions 2, 4 and 16 also accepted
// - bit reads of fault flags from 1664
// - writable registers below 100 are volatile
// - writable registers above 100 are retained
// - setpoint 0 to 10000 is 0 to 100 percent
// - override 2 closes, 3 forces minimum
// - relative and absolute position at 4, 5
// - flow values at 6, 7, flow variants
// - auxiliary sensor reading at address 8
// - serial at 100 to 102, version 103
// - fault flags at 104, also bitwise readable
// - rated flow at address 110
// - command register 2 starts service, self-clears
`ifndef DMB_CONSTS_SVH
`define DMB_CONSTS_SVH

// ****************************************
// table addresses
// ****************************************
`define DMB_ADR_SETPOINT   16'h0000
`define DMB_ADR_FORCED     16'h0001
`define DMB_ADR_COMMAND    16'h0002
`define DMB_ADR_CATEGORY   16'h0003
`define DMB_ADR_POS_PCT    16'h0004
`define DMB_ADR_POS_ABS    16'h0005
`define DMB_ADR_FLOW_PCT   16'h0006
`define DMB_ADR_FLOW_ABS   16'h0007
`define DMB_ADR_AUX_VAL    16'h0008
`define DMB_ADR_SERIAL_1   16'h0064
`define DMB_ADR_SERIAL_2   16'h0065
`define DMB_ADR_SERIAL_4   16'h0066
`define DMB_ADR_VERSION    16'h0067
`define DMB_ADR_FAULTS     16'h0068
`define DMB_ADR_LOWER      16'h0069
`define DMB_ADR_UPPER      16'h006A
`define DMB_ADR_AUX_KIND   16'h006B
`define DMB_ADR_LOSS_POS   16'h006C
`define DMB_ADR_RESERVED   16'h006D
`define DMB_ADR_RATED      16'h006E
`define DMB_BIT_BASE       16'h0680
`define DMB_BIT_COUNT      16'h0010

// ****************************************
// function and exception codes
// ****************************************
`define DMB_FC_RD_BITS     8'h02
`define DMB_FC_RD_HOLD     8'h03
`define DMB_FC_RD_INPUT    8'h04
`define DMB_FC_WR_SINGLE   8'h06
`define DMB_FC_WR_MULTI    8'h10
`define DMB_EXC_NONE       8'h00
`define DMB_EXC_FUNC       8'h01
`define DMB_EXC_ADDR       8'h02
`define DMB_EXC_VALUE      8'h03

// ****************************************
// values and reset values
// ****************************************
`define DMB_PCT_FULL       16'h2710
`define DMB_FORCE_NONE     16'h0000
`define DMB_FORCE_OPEN     16'h0001
`define DMB_FORCE_CLOSE    16'h0002
`define DMB_FORCE_MIN      16'h0003
`define DMB_CMD_NONE       16'h0000
`define DMB_CMD_LAST       16'h0004
`define DMB_RST_WORD       16'h0000

`endif

// [logic/dmb_pkg.sv]
// types shared by the damper actuator modbus register bank
// assumes the constants header is included by the users of these types
package dmb_pkg;
    typedef logic [15:0] dmb_word_t;
    typedef logic [7:0]  dmb_code_t;
    // class of a request beat after decoding
    typedef enum logic [1:0] {
        DMB_KIND_READ,
        DMB_KIND_BITS,
        DMB_KIND_WRITE,
        DMB_KIND_BAD
    } dmb_kind_t;
endpackage

// [logic/dmb_regbank.sv]
// register bank of the damper actuator behind its modbus slave
// assumes a framer on clk_i that splits multi-register frames into beats,
// one register (or one bit) per beat, and an external retained store
`timescale 1ns/100ps
`default_nettype none
`include "dmb_consts.svh"

module dmb_regbank #(
    parameter logic [15:0] SERIAL_1 = 16'h1234, // arbitrary value
    parameter logic [15:0] SERIAL_2 = 16'h5678, // arbitrary value
    parameter logic [15:0] SERIAL_4 = 16'h9ABC, // arbitrary value
    parameter logic [15:0] VERSION  = 16'h0101  // arbitrary value
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // request beat from the framer
    input  wire logic               req_valid_i,
    input  wire dmb_pkg::dmb_code_t req_func_i,
    input  wire dmb_pkg::dmb_word_t req_addr_i,
    input  wire dmb_pkg::dmb_word_t req_wdata_i,
    // answer beat to the framer
    output logic                    rsp_valid_o,
    output dmb_pkg::dmb_word_t      rsp_data_o,
    output dmb_pkg::dmb_code_t      rsp_exc_o,
    // measurements from the actuator core
    input  wire dmb_pkg::dmb_word_t category_i,
    input  wire dmb_pkg::dmb_word_t pos_pct_i,
    input  wire dmb_pkg::dmb_word_t pos_abs_i,
    input  wire dmb_pkg::dmb_word_t flow_pct_i,
    input  wire dmb_pkg::dmb_word_t flow_abs_i,
    input  wire dmb_pkg::dmb_word_t aux_val_i,
    input  wire dmb_pkg::dmb_word_t faults_i,
    input  wire dmb_pkg::dmb_word_t rated_i,
    // retained store, loaded at reset
    input  wire dmb_pkg::dmb_word_t nv_lower_i,
    input  wire dmb_pkg::dmb_word_t nv_upper_i,
    input  wire dmb_pkg::dmb_word_t nv_aux_kind_i,
    input  wire dmb_pkg::dmb_word_t nv_loss_pos_i,
    output dmb_pkg::dmb_word_t      nv_lower_o,
    output dmb_pkg::dmb_word_t      nv_upper_o,
    output dmb_pkg::dmb_word_t      nv_aux_kind_o,
    output dmb_pkg::dmb_word_t      nv_loss_pos_o,
    // demands to the actuator core
    output dmb_pkg::dmb_word_t      demand_o,
    output dmb_pkg::dmb_word_t      command_o,
    input  wire logic               cmd_done_i
);

    // ****************************************
    // request decode
    // ****************************************
    dmb_pkg::dmb_kind_t kind;
    dmb_pkg::dmb_word_t bit_off;
    wire fc_read  = (req_func_i == `DMB_FC_RD_HOLD)
                  | (req_func_i == `DMB_FC_RD_INPUT);
    wire fc_bits  = (req_func_i == `DMB_FC_RD_BITS);
    wire fc_write = (req_func_i == `DMB_FC_WR_SINGLE)
                  | (req_func_i == `DMB_FC_WR_MULTI);
    assign kind = fc_read  ? dmb_pkg::DMB_KIND_READ  :
                  fc_bits  ? dmb_pkg::DMB_KIND_BITS  :
                  fc_write ? dmb_pkg::DMB_KIND_WRITE :
                             dmb_pkg::DMB_KIND_BAD;
    // bit reads only cover the fault word, 16 bits from the base
    assign bit_off = req_addr_i - `DMB_BIT_BASE;
    wire bit_hit = (req_addr_i >= `DMB_BIT_BASE)
                 & (bit_off < `DMB_BIT_COUNT);

    // ****************************************
    // storage
    // ****************************************
    dmb_pkg::dmb_word_t setpoint_q, forced_q, command_q;
    dmb_pkg::dmb_word_t lower_q, upper_q, aux_kind_q, loss_pos_q;
    dmb_pkg::dmb_word_t demand_q;
    logic               rsp_valid_q;
    dmb_pkg::dmb_word_t rsp_data_q;
    dmb_pkg::dmb_code_t rsp_exc_q;

    // ****************************************
    // read selection over the flat table
    // ****************************************
    dmb_pkg::dmb_word_t rd_data;
    logic               rd_hit;
    // one flat table, address = register number - 1
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = `DMB_RST_WORD;
        case (req_addr_i)
            `DMB_ADR_SETPOINT: rd_data = setpoint_q;
            `DMB_ADR_FORCED:   rd_data = forced_q;
            `DMB_ADR_COMMAND:  rd_data = command_q;
            `DMB_ADR_CATEGORY: rd_data = category_i;
            `DMB_ADR_POS_PCT:  rd_data = pos_pct_i;
            `DMB_ADR_POS_ABS:  rd_data = pos_abs_i;
            `DMB_ADR_FLOW_PCT: rd_data = flow_pct_i;
            `DMB_ADR_FLOW_ABS: rd_data = flow_abs_i;
            `DMB_ADR_AUX_VAL:  rd_data = aux_val_i;
            `DMB_ADR_SERIAL_1: rd_data = SERIAL_1;
            `DMB_ADR_SERIAL_2: rd_data = SERIAL_2;
            `DMB_ADR_SERIAL_4: rd_data = SERIAL_4;
            `DMB_ADR_VERSION:  rd_data = VERSION;
            `DMB_ADR_FAULTS:   rd_data = faults_i;
            `DMB_ADR_LOWER:    rd_data = lower_q;
            `DMB_ADR_UPPER:    rd_data = upper_q;
            `DMB_ADR_AUX_KIND: rd_data = aux_kind_q;
            `DMB_ADR_LOSS_POS: rd_data = loss_pos_q;
            `DMB_ADR_RESERVED: rd_data = `DMB_RST_WORD;
            `DMB_ADR_RATED:    rd_data = rated_i;
            default:           rd_hit  = 1'b0;
        endcase
    end

    // ****************************************
    // write checks
    // ****************************************
    // only the writable entries accept a write; all but aux kind and loss position have a value range
    wire a_set  = (req_addr_i == `DMB_ADR_SETPOINT);
    wire a_frc  = (req_addr_i == `DMB_ADR_FORCED);
    wire a_cmd  = (req_addr_i == `DMB_ADR_COMMAND);
    wire a_low  = (req_addr_i == `DMB_ADR_LOWER);
    wire a_upp  = (req_addr_i == `DMB_ADR_UPPER);
    wire a_kind = (req_addr_i == `DMB_ADR_AUX_KIND);
    wire a_loss = (req_addr_i == `DMB_ADR_LOSS_POS);
    wire wr_hit = a_set | a_frc | a_cmd | a_low | a_upp | a_kind | a_loss;
    wire pct_ok = (req_wdata_i <= `DMB_PCT_FULL);
    wire val_ok = ((a_set | a_low | a_upp) ? pct_ok : 1'b1)
                & (a_frc ? (req_wdata_i <= `DMB_FORCE_MIN) : 1'b1)
                & (a_cmd ? (req_wdata_i <= `DMB_CMD_LAST) : 1'b1);
    wire wr_go  = req_valid_i & (kind == dmb_pkg::DMB_KIND_WRITE)
                & wr_hit & val_ok;

    // ****************************************
    // answer
    // ****************************************
    dmb_pkg::dmb_code_t exc_d;
    dmb_pkg::dmb_word_t data_d;
    // an exception is always returned instead of undefined data
    assign exc_d =
        (kind == dmb_pkg::DMB_KIND_BAD)                ? `DMB_EXC_FUNC :
        (kind == dmb_pkg::DMB_KIND_READ  && !rd_hit)   ? `DMB_EXC_ADDR :
        (kind == dmb_pkg::DMB_KIND_BITS  && !bit_hit)  ? `DMB_EXC_ADDR :
        (kind == dmb_pkg::DMB_KIND_WRITE && !wr_hit)   ? `DMB_EXC_ADDR :
        (kind == dmb_pkg::DMB_KIND_WRITE && !val_ok)   ? `DMB_EXC_VALUE :
                                                         `DMB_EXC_NONE;
    // bit path returns the addressed fault bit in bit 0
    assign data_d =
        (exc_d != `DMB_EXC_NONE)             ? `DMB_RST_WORD :
        (kind == dmb_pkg::DMB_KIND_BITS)     ?
            {15'h0000, faults_i[bit_off[3:0]]} :
        (kind == dmb_pkg::DMB_KIND_WRITE)    ? req_wdata_i : rd_data;

    // answer one cycle after every beat
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= `DMB_RST_WORD;
            rsp_exc_q   <= `DMB_EXC_NONE;
        end
        else
        begin
            rsp_valid_q <= req_valid_i;
            rsp_data_q  <= req_valid_i ? data_d : `DMB_RST_WORD;
            rsp_exc_q   <= req_valid_i ? exc_d : `DMB_EXC_NONE;
        end
    end

    // ****************************************
    // volatile operation registers
    // ****************************************
    // lost at reset; the master refreshes them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            setpoint_q <= `DMB_RST_WORD;
            forced_q   <= `DMB_FORCE_NONE;
        end
        else
        begin
            if (wr_go && a_set)
                setpoint_q <= req_wdata_i;
            if (wr_go && a_frc)
                forced_q <= req_wdata_i;
        end
    end

    // command clears itself once the core has acted; a write in the
    // same cycle as the done pulse wins so no command is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            command_q <= `DMB_CMD_NONE;
        else if (wr_go && a_cmd)
            command_q <= req_wdata_i;
        else if (cmd_done_i)
            command_q <= `DMB_CMD_NONE;
    end

    // ****************************************
    // retained service registers
    // ****************************************
    // reloaded from the retained store at reset, never cleared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lower_q    <= nv_lower_i;
            upper_q    <= nv_upper_i;
            aux_kind_q <= nv_aux_kind_i;
            loss_pos_q <= nv_loss_pos_i;
        end
        else
        begin
            if (wr_go && a_low)
                lower_q <= req_wdata_i;
            if (wr_go && a_upp)
                upper_q <= req_wdata_i;
            if (wr_go && a_kind)
                aux_kind_q <= req_wdata_i;
            if (wr_go && a_loss)
                loss_pos_q <= req_wdata_i;
        end
    end

    // ****************************************
    // effective demand
    // ****************************************
    dmb_pkg::dmb_word_t demand_d;
    // forced states take the setpoint's place
    assign demand_d =
        (forced_q == `DMB_FORCE_OPEN)  ? `DMB_PCT_FULL :
        (forced_q == `DMB_FORCE_CLOSE) ? `DMB_RST_WORD :
        (forced_q == `DMB_FORCE_MIN)   ? lower_q :
                                         setpoint_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            demand_q <= `DMB_RST_WORD;
        else
            demand_q <= demand_d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rsp_valid_o   = rsp_valid_q;
    assign rsp_data_o    = rsp_data_q;
    assign rsp_exc_o     = rsp_exc_q;
    assign demand_o      = demand_q;
    assign command_o     = command_q;
    assign nv_lower_o    = lower_q;
    assign nv_upper_o    = upper_q;
    assign nv_aux_kind_o = aux_kind_q;
    assign nv_loss_pos_o = loss_pos_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking dmb_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_answer_next_cycle: assert property (
        req_valid_i |=> rsp_valid_o ##1 (!rsp_valid_o || $past(req_valid_i)))
        else $error("answer beat not one cycle after request");

    a_bad_func_exc: assert property (
        (req_valid_i && !fc_read && !fc_bits && !fc_write)
        |=> rsp_exc_o == `DMB_EXC_FUNC)
        else $error("unknown function not refused");

    a_hold_read_ok: assert property (
        (req_valid_i && req_func_i == `DMB_FC_RD_HOLD
         && req_addr_i == `DMB_ADR_VERSION)
        |=> rsp_exc_o == `DMB_EXC_NONE && rsp_data_o == VERSION)
        else $error("version read wrong");

    a_unmapped_addr: assert property (
        (req_valid_i && fc_read && req_addr_i == 16'h0009)
        |=> rsp_exc_o == `DMB_EXC_ADDR)
        else $error("unmapped address not refused");

    a_bit_read_path: assert property (
        (req_valid_i && fc_bits && req_addr_i == `DMB_BIT_BASE)
        |=> rsp_exc_o == `DMB_EXC_NONE
            && rsp_data_o == {15'h0000, $past(faults_i[0])})
        else $error("fault bit read wrong");

    a_setpoint_range: assert property (
        setpoint_q <= `DMB_PCT_FULL)
        else $error("setpoint above full scale");

    a_force_open: assert property (
        forced_q == `DMB_FORCE_OPEN |=> demand_o == `DMB_PCT_FULL)
        else $error("open override not applied");

    a_force_close_min: assert property (
        (forced_q == `DMB_FORCE_CLOSE |=> demand_o == `DMB_RST_WORD)
        and (forced_q == `DMB_FORCE_MIN |=> demand_o == $past(lower_q)))
        else $error("close or min override not applied");

    a_command_clear: assert property (
        (cmd_done_i && !(wr_go && a_cmd)) |=> command_o == `DMB_CMD_NONE)
        else $error("command not cleared after done");

    a_write_stores: assert property (
        (wr_go && a_set) |=> setpoint_q == $past(req_wdata_i)
                             && rsp_exc_o == `DMB_EXC_NONE)
        else $error("setpoint write lost");

    c_multi_write: cover property (
        req_valid_i && req_func_i == `DMB_FC_WR_MULTI ##1
        req_valid_i && req_func_i == `DMB_FC_WR_MULTI);
    c_bit_read: cover property (req_valid_i && fc_bits && bit_hit);
    c_force_min: cover property (forced_q == `DMB_FORCE_MIN);
    c_cmd_cycle: cover property (command_o != `DMB_CMD_NONE ##[1:20]
                                 command_o == `DMB_CMD_NONE);

endmodule
`default_nettype wire
